// ### isl_pkg.sv
// isl_pkg: constants for the interrupt status and loss-of-signal status block
package isl_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ISL_OFS_INT_ENABLE = 8'h00;
  localparam logic [7:0] ISL_OFS_INT_STATUS = 8'h04;
  localparam logic [7:0] ISL_OFS_MON_CTRL = 8'h08;
  localparam logic [7:0] ISL_OFS_MON0_STS = 8'h0c;
  localparam logic [7:0] ISL_OFS_MON1_STS = 8'h10;
  localparam logic [7:0] ISL_OFS_MON2_STS = 8'h14;
  localparam logic [7:0] ISL_OFS_LOS_EVENT = 8'h18;
  localparam logic [7:0] ISL_OFS_PIN_SEL = 8'h1c;

  // ----------------------------------------------------------------------
  // interrupt status / enable layout
  // ----------------------------------------------------------------------
  localparam int ISL_BIT_DEVICE = 15;
  localparam int ISL_BIT_LOAD_FAIL = 11;
  localparam int ISL_BIT_LOAD_ERR = 10;
  localparam int ISL_BIT_OTP_RDY = 9;
  localparam int ISL_BIT_ACT1 = 8;
  localparam int ISL_BIT_ACT0 = 7;
  localparam int ISL_BIT_LOS2 = 6;
  localparam int ISL_BIT_LOS1 = 5;
  localparam int ISL_BIT_LOS0 = 4;
  localparam int ISL_BIT_DPLL_STATE = 3;
  localparam int ISL_BIT_DPLL_HOLD = 2;
  localparam int ISL_BIT_DPLL_LOL = 1;
  localparam int ISL_BIT_APLL_LOL = 0;
  localparam logic [15:0] ISL_INT_EN_MASK = 16'h8fff;
  localparam logic [15:0] ISL_INT_EN_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // monitor status, control and event layout
  // ----------------------------------------------------------------------
  localparam int ISL_MON_COUNT = 3;
  localparam int ISL_LOADER_BITS = 4;
  localparam int ISL_STS_LOS = 0;
  localparam int ISL_STS_INVALID = 1;
  localparam logic ISL_LOS_STS_RESET = 1'b1;
  localparam logic ISL_INVALID_RESET = 1'b1;
  localparam logic ISL_LOS_EVT_RESET = 1'b1;
  // mon_ctrl: bits 2:0 soft reset, 6:4 ref disable, 10:8 los fail mask
  localparam int ISL_CTRL_SRST_POS = 0;
  localparam int ISL_CTRL_DIS_POS = 4;
  localparam int ISL_CTRL_MASK_POS = 8;
  localparam logic [31:0] ISL_CTRL_RW_MASK = 32'h0000_0777;
  localparam logic [31:0] ISL_CTRL_RESET = 32'h0000_0000;
  localparam logic ISL_PIN_SEL_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] ISL_RESP_OKAY = 2'b00;
  localparam logic [1:0] ISL_RESP_SLVERR = 2'b10;

endpackage : isl_pkg

// ### isl_top.sv
// isl_top: interrupt status aggregation and loss-of-signal status registers
`timescale 1ns/100ps

module isl_top (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // event bits from the surrounding blocks
  input wire logic [isl_pkg::ISL_LOADER_BITS-1:0] load_fail_evt_in,
  input wire logic [isl_pkg::ISL_LOADER_BITS-1:0] crc_err_evt_in,
  input wire logic otp_manual_rdy_evt_in,
  input wire logic activity_flag_complement_input_in,
  input wire logic activity_flag_true_input_in,
  input wire logic digital_loop_state_change_flag_in,
  input wire logic digital_loop_holdover_flag_in,
  input wire logic digital_loop_lock_loss_flag_in,
  input wire logic analog_loop_lock_loss_flag_in,
  // monitor levels: 0 true input, 1 complement input, 2 crystal
  input wire logic [isl_pkg::ISL_MON_COUNT-1:0] signal_loss_level_in,
  input wire logic [1:0] activity_disqualify_in,
  input wire logic lock_indicator_in,
  // outputs
  output logic status_pin_out,
  output logic irq_out,
  output logic [isl_pkg::ISL_MON_COUNT-1:0] monitor_soft_reset_out,
  output logic [isl_pkg::ISL_MON_COUNT-1:0] ref_invalid_out
);
  import isl_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0] int_enable, next_int_enable;
  logic [15:0] interrupt_status, next_interrupt_status;
  logic [31:0] mon_ctrl, next_mon_ctrl;
  logic pin_sel, next_pin_sel;
  logic [ISL_MON_COUNT-1:0] los_sts, next_los_sts;
  logic [ISL_MON_COUNT-1:0] ref_invalid, next_ref_invalid;
  logic [ISL_MON_COUNT-1:0] los_evt, next_los_evt;
  logic irq, next_irq;
  logic status_pin, next_status_pin;

  // bus handshake state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // ready flags kept as flops so every bus output leaves a register
  logic aw_ready, next_aw_ready;
  logic w_ready, next_w_ready;
  logic ar_ready, next_ar_ready;

  logic do_write;
  logic [31:0] wmask;
  logic [ISL_MON_COUNT-1:0] evt_clear;
  logic [ISL_MON_COUNT-1:0] ref_disable, fail_mask;
  logic [ISL_MON_COUNT-1:0] act_disq;
  logic [15:0] enabled_src;

  // ----------------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  // ready is low while a beat is held so the master keeps it for later
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid_in && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_in;
      next_w_strb = s_axi_wstrb_in;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case (aw_addr)
        ISL_OFS_INT_ENABLE, ISL_OFS_INT_STATUS, ISL_OFS_MON_CTRL,
        ISL_OFS_MON0_STS, ISL_OFS_MON1_STS, ISL_OFS_MON2_STS,
        ISL_OFS_LOS_EVENT, ISL_OFS_PIN_SEL: next_bresp = ISL_RESP_OKAY;
        default: next_bresp = ISL_RESP_SLVERR;
      endcase
    end else if (bvalid && s_axi_bready_in) begin
      next_bvalid = 1'b0;
    end
    // ready is the inverse of the held flags one to one
    next_aw_ready = !next_aw_held;
    next_w_ready = !next_w_held;
  end

  // a write commits once both beats are held and no answer is pending
  assign do_write = aw_held && w_held && !bvalid;

  // byte enables widened to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{w_strb[i]}};
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  // status words take no write at all, the answer is still okay
  always_comb begin
    next_int_enable = int_enable;
    next_mon_ctrl = mon_ctrl;
    next_pin_sel = pin_sel;
    evt_clear = '0;
    if (do_write) begin
      case (aw_addr)
        ISL_OFS_INT_ENABLE: begin
          next_int_enable = ((int_enable & ~wmask[15:0])
            | (w_data[15:0] & wmask[15:0])) & ISL_INT_EN_MASK;
        end
        ISL_OFS_MON_CTRL: begin
          next_mon_ctrl = ((mon_ctrl & ~wmask) | (w_data & wmask))
            & ISL_CTRL_RW_MASK;
        end
        ISL_OFS_LOS_EVENT: begin
          evt_clear = w_data[ISL_MON_COUNT-1:0] & wmask[ISL_MON_COUNT-1:0];
        end
        ISL_OFS_PIN_SEL: begin
          if (w_strb[0]) begin
            next_pin_sel = w_data[0];
          end
        end
        default: begin
          next_int_enable = int_enable;
        end
      endcase
    end
  end

  assign ref_disable = mon_ctrl[ISL_CTRL_DIS_POS +: ISL_MON_COUNT];
  assign fail_mask = mon_ctrl[ISL_CTRL_MASK_POS +: ISL_MON_COUNT];
  // crystal monitor has no activity check
  assign act_disq = {1'b0, activity_disqualify_in};

  // ----------------------------------------------------------------------
  // monitor status and sticky loss events
  // ----------------------------------------------------------------------
  // the crystal monitor cannot be deselected, so its disable is ignored
  always_comb begin
    next_los_sts = signal_loss_level_in;
    for (int m = 0; m < ISL_MON_COUNT; m++) begin
      next_ref_invalid[m] = (signal_loss_level_in[m] && !fail_mask[m])
        || act_disq[m]
        || (ref_disable[m] && (m != ISL_MON_COUNT - 1));
      // set wins over clear, so a live loss keeps it set
      next_los_evt[m] = signal_loss_level_in[m]
        || (los_evt[m] && !evt_clear[m]);
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status word and device interrupt
  // ----------------------------------------------------------------------
  always_comb begin
    next_interrupt_status = '0;
    next_interrupt_status[ISL_BIT_LOAD_FAIL] = |load_fail_evt_in;
    next_interrupt_status[ISL_BIT_LOAD_ERR] = |crc_err_evt_in;
    next_interrupt_status[ISL_BIT_OTP_RDY] = otp_manual_rdy_evt_in;
    next_interrupt_status[ISL_BIT_ACT1] =
      activity_flag_complement_input_in;
    next_interrupt_status[ISL_BIT_ACT0] = activity_flag_true_input_in;
    next_interrupt_status[ISL_BIT_LOS2] = los_evt[2];
    next_interrupt_status[ISL_BIT_LOS1] = los_evt[1];
    next_interrupt_status[ISL_BIT_LOS0] = los_evt[0];
    next_interrupt_status[ISL_BIT_DPLL_STATE] =
      digital_loop_state_change_flag_in;
    next_interrupt_status[ISL_BIT_DPLL_HOLD] =
      digital_loop_holdover_flag_in;
    next_interrupt_status[ISL_BIT_DPLL_LOL] =
      digital_loop_lock_loss_flag_in;
    next_interrupt_status[ISL_BIT_APLL_LOL] =
      analog_loop_lock_loss_flag_in;
    // enable of 0 drops the source out of the summary
    enabled_src = next_interrupt_status & int_enable;
    enabled_src[ISL_BIT_DEVICE] = 1'b0;
    next_interrupt_status[ISL_BIT_DEVICE] = |enabled_src;
  end

  // one register stage from status to pin keeps the outputs glitch free
  // lock level is taken as is, so it must come from this clock
  always_comb begin
    next_irq = interrupt_status[ISL_BIT_DEVICE]
      && int_enable[ISL_BIT_DEVICE];
    next_status_pin = pin_sel ? next_irq : lock_indicator_in;
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  // a single outstanding read; arready is low while the answer waits
  always_comb begin
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (s_axi_arvalid_in && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = ISL_RESP_OKAY;
      next_rdata = '0;
      case (s_axi_araddr_in)
        ISL_OFS_INT_ENABLE: next_rdata[15:0] = int_enable;
        ISL_OFS_INT_STATUS: next_rdata[15:0] = interrupt_status;
        ISL_OFS_MON_CTRL: next_rdata = mon_ctrl;
        ISL_OFS_MON0_STS: next_rdata[1:0] = {ref_invalid[0], los_sts[0]};
        ISL_OFS_MON1_STS: next_rdata[1:0] = {ref_invalid[1], los_sts[1]};
        ISL_OFS_MON2_STS: next_rdata[1:0] = {ref_invalid[2], los_sts[2]};
        ISL_OFS_LOS_EVENT: next_rdata[ISL_MON_COUNT-1:0] = los_evt;
        ISL_OFS_PIN_SEL: next_rdata[0] = pin_sel;
        default: next_rresp = ISL_RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready_in) begin
      next_rvalid = 1'b0;
    end
    // address ready drops while an answer stands
    next_ar_ready = !next_rvalid;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // synchronous reset, all state registered in one place
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      int_enable <= ISL_INT_EN_RESET;
      interrupt_status <= '0;
      mon_ctrl <= ISL_CTRL_RESET;
      pin_sel <= ISL_PIN_SEL_RESET;
      los_sts <= {ISL_MON_COUNT{ISL_LOS_STS_RESET}};
      ref_invalid <= {ISL_MON_COUNT{ISL_INVALID_RESET}};
      los_evt <= {ISL_MON_COUNT{ISL_LOS_EVT_RESET}};
      irq <= 1'b0;
      status_pin <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= ISL_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= ISL_RESP_OKAY;
      rdata <= '0;
      aw_ready <= 1'b1;
      w_ready <= 1'b1;
      ar_ready <= 1'b1;
    end else begin
      int_enable <= next_int_enable;
      interrupt_status <= next_interrupt_status;
      mon_ctrl <= next_mon_ctrl;
      pin_sel <= next_pin_sel;
      los_sts <= next_los_sts;
      ref_invalid <= next_ref_invalid;
      los_evt <= next_los_evt;
      irq <= next_irq;
      status_pin <= next_status_pin;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      aw_ready <= next_aw_ready;
      w_ready <= next_w_ready;
      ar_ready <= next_ar_ready;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------------
  // ready flags come from their own flops, not from inverted held flags
  assign s_axi_awready_out = aw_ready;
  assign s_axi_wready_out = w_ready;
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;
  assign s_axi_arready_out = ar_ready;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rresp_out = rresp;
  assign s_axi_rdata_out = rdata;
  assign irq_out = irq;
  assign status_pin_out = status_pin;
  assign monitor_soft_reset_out = mon_ctrl[ISL_CTRL_SRST_POS +: ISL_MON_COUNT];
  assign ref_invalid_out = ref_invalid;

endmodule : isl_top

// ### isl_top_asserts.sv
// isl_top_asserts: port-level checks for the status block
`timescale 1ns/100ps
module isl_top_asserts (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic [1:0] activity_disqualify_in,
  input wire logic irq_out,
  input wire logic [isl_pkg::ISL_MON_COUNT-1:0] monitor_soft_reset_out,
  input wire logic [isl_pkg::ISL_MON_COUNT-1:0] ref_invalid_out
);
  import isl_pkg::*;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // write steps: both halves taken, then the answer
  sequence s_both_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out;
  endsequence
  sequence s_resp_due;
    ##[1:4] s_axi_bvalid_out;
  endsequence
  chk_write_resp:
    assert property (s_both_taken |-> s_resp_due)
    else $error("write answer missing");
  chk_read_answer:
    assert property (s_axi_arvalid_in && s_axi_arready_out |=>
      s_axi_rvalid_out)
    else $error("read answer missing");
  chk_unmapped_read:
    assert property (s_axi_arvalid_in && s_axi_arready_out &&
      s_axi_araddr_in > 8'h1c |=> s_axi_rresp_out == ISL_RESP_SLVERR &&
      s_axi_rdata_out == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_bvalid_drop:
    assert property (s_axi_bvalid_out && s_axi_bready_in |=>
      !s_axi_bvalid_out)
    else $error("write answer stands after taken");
  chk_reset_vals:
    assert property ($rose(rst_b_in) |-> ref_invalid_out == 3'h7 &&
      !irq_out && monitor_soft_reset_out == 3'h0)
    else $error("wrong values out of reset");
  chk_disq_invalid:
    assert property (activity_disqualify_in[1] |=> ref_invalid_out[1])
    else $error("disqualified reference not invalid");
  chk_soft_rst_cause:
    assert property ($changed(monitor_soft_reset_out) |->
      s_axi_bvalid_out)
    else $error("soft reset moved without a write");
  chk_arready_link:
    assert property (s_axi_arready_out == !s_axi_rvalid_out)
    else $error("read address ready wrong");
endmodule : isl_top_asserts

bind isl_top isl_top_asserts u_chk (.*);

// ### isl_top_tb.sv
// isl_top_tb: self-checking bench for the status block
`timescale 1ns/100ps
module isl_top_tb;
  import isl_pkg::*;
  logic ref_clk_in = 0, rst_b_in = 0, s_axi_awvalid_in = 0;
  logic s_axi_wvalid_in = 0, s_axi_arvalid_in = 0;
  logic s_axi_bready_in = 1, s_axi_rready_in = 1, lock_indicator_in = 0;
  logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, rnd = 32'h4686_7a0a;
  logic [3:0] s_axi_wstrb_in = 4'hf, load_fail_evt_in, crc_err_evt_in;
  logic [3:0] pat = 4'h1;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, status_pin_out, irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, activity_disqualify_in = 0;
  logic otp_manual_rdy_evt_in, activity_flag_complement_input_in;
  logic activity_flag_true_input_in, digital_loop_state_change_flag_in;
  logic digital_loop_holdover_flag_in, digital_loop_lock_loss_flag_in;
  logic analog_loop_lock_loss_flag_in;
  logic [2:0] signal_loss_level_in = 3'h0, monitor_soft_reset_out;
  logic [2:0] ref_invalid_out;
  logic [11:0] src = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int err_count = 0, n_compared = 0, cyc = 0;
  // event sources laid out as their status bits
  assign analog_loop_lock_loss_flag_in = src[0];
  assign digital_loop_lock_loss_flag_in = src[1];
  assign digital_loop_holdover_flag_in = src[2];
  assign digital_loop_state_change_flag_in = src[3];
  assign activity_flag_true_input_in = src[7];
  assign activity_flag_complement_input_in = src[8];
  assign otp_manual_rdy_evt_in = src[9];
  assign crc_err_evt_in = src[10] ? pat : 4'h0;
  assign load_fail_evt_in = src[11] ? pat : 4'h0;
  isl_top dut (.*);
  // clock
  always #12.5 ref_clk_in = ~ref_clk_in;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // inputs move on the edge, outputs read after it lands
  task settle;
    repeat (4) @(posedge ref_clk_in);
    #1;
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = ISL_RESP_OKAY);
    bit ad = 0, wd = 0;
    bq.push_back(r);
    @(posedge ref_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    while (!(ad && wd)) begin
      @(posedge ref_clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        ad = 1;
        s_axi_awvalid_in <= 0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wd = 1;
        s_axi_wvalid_in <= 0;
      end
    end
    while (!s_axi_bvalid_out) @(posedge ref_clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = ISL_RESP_OKAY);
    rq.push_back({r, d});
    @(posedge ref_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    do @(posedge ref_clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 0;
    do @(posedge ref_clk_in); while (!s_axi_rvalid_out);
  endtask : rd
  // answer watcher: oldest note against each answer
  always @(posedge ref_clk_in) begin
    if (s_axi_rvalid_out && s_axi_rready_in)
      check({s_axi_rresp_out, s_axi_rdata_out}, rq.pop_front());
    if (s_axi_bvalid_out && s_axi_bready_in)
      check(s_axi_bresp_out, bq.pop_front());
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_b_in <= 1;
    for (int i = 0; i < 3; i++) rd(ISL_OFS_MON0_STS + 8'(4 * i), 0);
    rd(ISL_OFS_LOS_EVENT, 32'h0000_0007);
    rd(ISL_OFS_INT_STATUS, 32'h0000_0070);
    $display("test reset finished");
    @(posedge ref_clk_in) signal_loss_level_in <= 3'h2;
    settle();
    wr(ISL_OFS_LOS_EVENT, 32'h0000_0007);
    rd(ISL_OFS_LOS_EVENT, 32'h0000_0002);
    rd(ISL_OFS_MON0_STS, 32'h0000_0000);
    @(posedge ref_clk_in) signal_loss_level_in <= 3'h0;
    settle();
    rd(ISL_OFS_LOS_EVENT, 32'h0000_0002);
    wr(ISL_OFS_LOS_EVENT, 32'h0000_0002);
    rd(ISL_OFS_INT_STATUS, 32'h0000_0000);
    $display("test loss events finished");
    for (int i = 0; i < 13; i++) begin
      if (i inside {[4:6]}) continue;
      rnd = lfsr(rnd);
      @(posedge ref_clk_in) src <= i < 12 ? 12'h001 << i : rnd[11:0] & 12'hf8f;
      pat <= 4'h1 << rnd[1:0];
      settle();
      rd(ISL_OFS_INT_STATUS, {20'h0, src});
    end
    $display("test mirrors finished");
    @(posedge ref_clk_in) src <= 12'h001;
    wr(ISL_OFS_INT_ENABLE, 32'hffff_ffff);
    rd(ISL_OFS_INT_ENABLE, {16'h0, ISL_INT_EN_MASK});
    s_axi_wstrb_in <= 4'h1;
    wr(ISL_OFS_INT_ENABLE, 32'h0000_0000);
    s_axi_wstrb_in <= 4'hf;
    rd(ISL_OFS_INT_ENABLE, 32'h0000_8f00);
    wr(ISL_OFS_INT_ENABLE, 32'h0000_0001);
    rd(ISL_OFS_INT_STATUS, 32'h0000_8001);
    #1 check(irq_out, 0);
    wr(ISL_OFS_INT_ENABLE, 32'h0000_8001);
    wr(ISL_OFS_PIN_SEL, 32'h0000_0001);
    settle();
    check(irq_out, 1);
    check(status_pin_out, 1);
    wr(ISL_OFS_INT_ENABLE, 32'h0000_8002);
    settle();
    check(irq_out, 0);
    rd(ISL_OFS_INT_STATUS, 32'h0000_0001);
    wr(ISL_OFS_INT_ENABLE, 32'h0000_0000);
    wr(ISL_OFS_PIN_SEL, 32'h0000_0000);
    @(posedge ref_clk_in) lock_indicator_in <= 1;
    settle();
    check(status_pin_out, 1);
    $display("test interrupt finished");
    wr(ISL_OFS_MON_CTRL, 32'h0000_0007);
    settle();
    check(monitor_soft_reset_out, 3'h7);
    wr(ISL_OFS_MON_CTRL, 32'h0000_0010);
    @(posedge ref_clk_in) activity_disqualify_in <= 2'h2;
    settle();
    check(ref_invalid_out, 3'h3);
    rd(ISL_OFS_MON0_STS, 32'h0000_0002);
    wr(ISL_OFS_MON_CTRL, 32'h0000_0400);
    @(posedge ref_clk_in) activity_disqualify_in <= 2'h0;
    signal_loss_level_in <= 3'h4;
    settle();
    check(ref_invalid_out, 3'h0);
    rd(ISL_OFS_MON2_STS, 32'h0000_0001);
    $display("test reference valid finished");
    wr(ISL_OFS_INT_STATUS, 32'hffff_ffff);
    wr(ISL_OFS_MON2_STS, 32'hffff_ffff);
    rd(ISL_OFS_INT_STATUS, 32'h0000_0041);
    rd(ISL_OFS_MON2_STS, 32'h0000_0001);
    wr(8'h40, 32'h0000_0000, ISL_RESP_SLVERR);
    rd(8'h40, 32'h0000_0000, ISL_RESP_SLVERR);
    $display("test refusals finished");
    settle();
    close_out();
  end
endmodule : isl_top_tb
